// ---- verilog/timer_extirq_control_reg.sv ----
// timer and external interrupt control register with its flag logic
// assumes: core SFR bus with byte and single-bit writes, one-cycle vector acks
//
// Overview of operation
// R1: register at SFR address 0x88, byte and single-bit access supported.
// R2: bit 7 timer 1 overflow flag, set by hardware, software clearable.
// R3: timer 1 overflow flag clears when core vectors to its routine.
// R4: bit 6 timer 1 run control enables counting, subject to gating.
// R5: bit 5 timer 0 overflow flag, set by hardware, software clearable.
// R6: timer 0 overflow flag clears when core vectors to its routine.
// R7: bit 4 timer 0 run control enables counting, subject to gating.
// R8: bit 3 external 1 flag, set by detector, vector clears in edge mode.
// R9: bit 2 external 1 type: 0 level, 1 edge.
// R10: bit 1 external 0 flag, set by detector, vector clears in edge mode.
// R11: bit 0 external 0 type: 0 level, 1 edge.
// R12: each external input polarity comes from its own polarity bit.
// R13: with gate set, timer counts only while run and input active; split mode ignores the timer 1 gate.
// R14: setting run bit never resets the timer count.
// R15: split mode: timer 0 high byte uses run 1, sets flag 1.
// R16: hardware set beats same-cycle software clear on every flag.
// R17: core pulses a vector acknowledge per source on routine entry.
`timescale 1ns/1ns
module timer_extirq_control_reg (
  input  wire logic                        clock,
  input  wire logic                        reset,
  input  wire logic [ctrl_pkg::ADDR_W-1:0] sfr_addr,
  input  wire logic [ctrl_pkg::DATA_W-1:0] sfr_wdata,
  input  wire logic                        sfr_write,
  input  wire logic                        sfr_bit_write,
  input  wire logic [ctrl_pkg::BIT_W-1:0]  sfr_bit_index,
  input  wire logic                        sfr_bit_value,
  input  wire logic                        sfr_read,
  output logic      [ctrl_pkg::DATA_W-1:0] sfr_rdata,
  output logic                             sfr_hit,
  input  wire logic                        timer0_overflow,
  input  wire logic                        timer0_high_overflow,
  input  wire logic                        timer1_overflow,
  input  wire logic                        timer0_split_mode,
  input  wire logic                        timer0_gate_enable,
  input  wire logic                        timer1_gate_enable,
  input  wire logic                        ext_request_0,
  input  wire logic                        ext_request_1_n,
  input  wire logic                        ext_request0_polarity,
  input  wire logic                        ext_request1_polarity,
  input  wire logic                        ack_timer0,
  input  wire logic                        ack_timer1,
  input  wire logic                        ack_ext0,
  input  wire logic                        ack_ext1,
  output logic                             timer0_count_enable,
  output logic                             timer0_high_count_enable,
  output logic                             timer1_count_enable,
  output logic                             timer0_overflow_flag,
  output logic                             timer1_overflow_flag,
  output logic                             ext_irq0_flag,
  output logic                             ext_irq1_flag
);
  import ctrl_pkg::*;

  logic                 timer1_overflow_flag_r;
  logic                 timer1_run_r;
  logic                 timer0_overflow_flag_r;
  logic                 timer0_run_r;
  logic                 ext_irq1_flag_r;
  logic                 ext_irq1_type_select_r;
  logic                 ext_irq0_flag_r;
  logic                 ext_irq0_type_select_r;
  logic [DATA_W-1:0]    control_value;
  logic [DATA_W-1:0]    rdata_r;
  logic                 addr_hit;
  logic [DATA_W-1:0]    wr_mask;
  logic [DATA_W-1:0]    wr_val;
  logic                 ext0_active;
  logic                 ext1_active;
  logic                 ext0_set;
  logic                 ext1_set;
  logic                 t1_flag_set;

  // address decode
  always_comb begin
    if (sfr_addr == SFR_ADDR_CONTROL) begin // R1
      addr_hit = 1'b1;
    end else begin
      addr_hit = 1'b0;
    end
  end

  assign sfr_hit = addr_hit & (sfr_read | sfr_write | sfr_bit_write);

  // byte write touches all bits, bit write only the addressed one
  always_comb begin
    wr_mask = '0;
    wr_val  = sfr_wdata;
    if (addr_hit && sfr_write) begin // R1
      wr_mask = {DATA_W{1'b1}};
    end else if (addr_hit && sfr_bit_write) begin // R1
      wr_mask                = '0;
      wr_mask[sfr_bit_index] = 1'b1;
      wr_val                 = {DATA_W{sfr_bit_value}};
    end
  end

  assign control_value = {timer1_overflow_flag_r, timer1_run_r,
                          timer0_overflow_flag_r, timer0_run_r,
                          ext_irq1_flag_r, ext_irq1_type_select_r,
                          ext_irq0_flag_r, ext_irq0_type_select_r};

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      rdata_r <= CONTROL_RESET;
    end else if (addr_hit && sfr_read) begin
      rdata_r <= control_value;
    end
  end

  assign sfr_rdata = rdata_r;

  ext_request_detect u_ext0 (
    .clock     (clock),
    .reset     (reset),
    .pin       (ext_request_0),
    .polarity  (ext_request0_polarity),
    .edge_mode (ext_irq0_type_select_r),
    .active    (ext0_active),
    .set_pulse (ext0_set)
  );

  ext_request_detect u_ext1 (
    .clock     (clock),
    .reset     (reset),
    .pin       (ext_request_1_n),
    .polarity  (ext_request1_polarity),
    .edge_mode (ext_irq1_type_select_r),
    .active    (ext1_active),
    .set_pulse (ext1_set)
  );

  timer_run_gate u_timer0_gate_enable (
    .run          (timer0_run_r),
    .gate_enable  (timer0_gate_enable),
    .ext_active   (ext0_active),
    .count_enable (timer0_count_enable)
  );

  // in split mode timer 1 loses its gate, and its flag goes to the timer 0 high byte
  timer_run_gate u_gate1 (
    .run          (timer1_run_r),
    .gate_enable  (timer1_gate_enable & ~timer0_split_mode),
    .ext_active   (ext1_active),
    .count_enable (timer1_count_enable)
  );

  assign timer0_high_count_enable = timer0_split_mode & timer1_run_r; // R15

  assign t1_flag_set = timer0_split_mode ? timer0_high_overflow : timer1_overflow; // R15

  // run bits: plain software state; count registers live elsewhere
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      timer1_run_r <= 1'b0;
    end else if (wr_mask[BIT_T1_RUN]) begin
      timer1_run_r <= wr_val[BIT_T1_RUN]; // R4 R14
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      timer0_run_r <= 1'b0;
    end else if (wr_mask[BIT_T0_RUN]) begin
      timer0_run_r <= wr_val[BIT_T0_RUN]; // R7 R14
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      ext_irq1_type_select_r <= 1'b0;
    end else if (wr_mask[BIT_X1_TYPE]) begin
      ext_irq1_type_select_r <= wr_val[BIT_X1_TYPE]; // R9
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      ext_irq0_type_select_r <= 1'b0;
    end else if (wr_mask[BIT_X0_TYPE]) begin
      ext_irq0_type_select_r <= wr_val[BIT_X0_TYPE]; // R11
    end
  end

  // flags: set first, so a same-cycle clear or ack never drops an event
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      timer1_overflow_flag_r <= 1'b0;
    end else if (t1_flag_set) begin
      timer1_overflow_flag_r <= 1'b1; // R2 R16
    end else if (ack_timer1) begin
      timer1_overflow_flag_r <= 1'b0; // R3 R17
    end else if (wr_mask[BIT_T1_OVF]) begin
      timer1_overflow_flag_r <= wr_val[BIT_T1_OVF]; // R2
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      timer0_overflow_flag_r <= 1'b0;
    end else if (timer0_overflow) begin
      timer0_overflow_flag_r <= 1'b1; // R5 R16
    end else if (ack_timer0) begin
      timer0_overflow_flag_r <= 1'b0; // R6 R17
    end else if (wr_mask[BIT_T0_OVF]) begin
      timer0_overflow_flag_r <= wr_val[BIT_T0_OVF]; // R5
    end
  end

  // level mode: ack leaves the flag, the pin sets it and only software clears it
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      ext_irq1_flag_r <= 1'b0;
    end else if (ext1_set) begin
      ext_irq1_flag_r <= 1'b1; // R8 R16
    end else if (ack_ext1 && ext_irq1_type_select_r == TYPE_EDGE) begin
      ext_irq1_flag_r <= 1'b0; // R8 R17
    end else if (wr_mask[BIT_X1_FLAG]) begin
      ext_irq1_flag_r <= wr_val[BIT_X1_FLAG]; // R8
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      ext_irq0_flag_r <= 1'b0;
    end else if (ext0_set) begin
      ext_irq0_flag_r <= 1'b1; // R10 R16
    end else if (ack_ext0 && ext_irq0_type_select_r == TYPE_EDGE) begin
      ext_irq0_flag_r <= 1'b0; // R10 R17
    end else if (wr_mask[BIT_X0_FLAG]) begin
      ext_irq0_flag_r <= wr_val[BIT_X0_FLAG]; // R10
    end
  end

  assign timer0_overflow_flag = timer0_overflow_flag_r;
  assign timer1_overflow_flag = timer1_overflow_flag_r;
  assign ext_irq0_flag        = ext_irq0_flag_r;
  assign ext_irq1_flag        = ext_irq1_flag_r;

endmodule // timer_extirq_control_reg

// ---- verilog/timer_and_ext_irq_control_pkg.sv ----
// package for the timer and external interrupt control register block
// assumes: an 8-bit special-function bus from the processor core
package ctrl_pkg;

  localparam logic [7:0] SFR_ADDR_CONTROL = 8'h88;
  localparam logic [7:0] CONTROL_RESET    = 8'h00;

  // bit positions inside the control register
  localparam int BIT_T1_OVF  = 7;
  localparam int BIT_T1_RUN  = 6;
  localparam int BIT_T0_OVF  = 5;
  localparam int BIT_T0_RUN  = 4;
  localparam int BIT_X1_FLAG = 3;
  localparam int BIT_X1_TYPE = 2;
  localparam int BIT_X0_FLAG = 1;
  localparam int BIT_X0_TYPE = 0;

  localparam logic TYPE_LEVEL = 1'b0;
  localparam logic TYPE_EDGE  = 1'b1;

  localparam int DATA_W = 8;
  localparam int ADDR_W = 8;
  localparam int BIT_W  = 3;

endpackage

// ---- verilog/ext_request_detect.sv ----
// edge or level detector for one external interrupt request pin
// assumes: pin asynchronous to clock; polarity from the configuration register
`timescale 1ns/1ns
module ext_request_detect (
  input  wire logic clock,
  input  wire logic reset,
  input  wire logic pin,
  input  wire logic polarity,
  input  wire logic edge_mode,
  output logic      active,
  output logic      set_pulse
);
  import ctrl_pkg::*;

  logic       sync1_r;
  logic       sync2_r;
  logic       prev_r;
  logic [1:0] fill_r;
  logic       prev_ok_r;

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
    end else begin
      sync1_r <= pin;
      sync2_r <= sync1_r;
    end
  end

  // polarity 1 = active high, 0 = active low
  assign active = ~(sync2_r ^ polarity); // R12

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      prev_r <= 1'b0;
    end else begin
      prev_r <= active;
    end
  end

  // reset leaves the synchroniser at 0, which reads as active on an active-low
  // pin; no set pulse until both stages hold samples, in edge mode the edge register too
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      fill_r    <= 2'h0;
      prev_ok_r <= 1'b0;
    end else begin
      fill_r    <= {fill_r[0], 1'b1};
      prev_ok_r <= fill_r[1];
    end
  end

  // level mode keeps requesting while the pin stays active
  assign set_pulse = (edge_mode == TYPE_EDGE) ? (prev_ok_r & active & ~prev_r)
                                              : (fill_r[1] & active); // R8 R10 R12

endmodule // ext_request_detect

// ---- verilog/timer_run_gate.sv ----
// count enable for one timer from run bit, gate bit and external input
// assumes: ext_active already synchronised and polarity applied
`timescale 1ns/1ns
module timer_run_gate (
  input  wire logic run,
  input  wire logic gate_enable,
  input  wire logic ext_active,
  output logic      count_enable
);
  // run bit only enables counting; count value is never cleared here
  assign count_enable = run & (~gate_enable | ext_active); // R13 R14

endmodule // timer_run_gate

// ---- bench/timer_and_ext_irq_control_assertions.sv ----
// property checker for the control register block
// assumes: bound into the block, one clock domain
`timescale 1ns/1ns
module ctrl_reg_checker (
  input wire logic       clock,
  input wire logic       reset,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic       sfr_write,
  input wire logic       sfr_bit_write,
  input wire logic       sfr_read,
  input wire logic [7:0] sfr_rdata,
  input wire logic       sfr_hit,
  input wire logic       timer0_overflow,
  input wire logic       timer0_high_overflow,
  input wire logic       timer1_overflow,
  input wire logic       timer0_split_mode,
  input wire logic       timer0_gate_enable,
  input wire logic       ack_timer0,
  input wire logic       ack_timer1,
  input wire logic       timer0_count_enable,
  input wire logic       timer0_overflow_flag,
  input wire logic       timer1_overflow_flag
);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  sequence s_byte_wr;
    sfr_write && sfr_addr == 8'h88;
  endsequence
  sequence s_read;
    sfr_read && sfr_hit;
  endsequence
  chk_hit_decode: assert property (sfr_hit == (sfr_addr == 8'h88 &&
    (sfr_write || sfr_bit_write || sfr_read))) else $error("hit decode");
  chk_read_data: assert property (s_read |=> sfr_rdata[7] == $past(timer1_overflow_flag)
    && sfr_rdata[5] == $past(timer0_overflow_flag)) else $error("read data");
  chk_rdata_hold: assert property (!(sfr_read && sfr_hit) |=> $stable(sfr_rdata))
    else $error("read data moved");
  chk_run_write: assert property (s_byte_wr ##1 !timer0_gate_enable |->
    timer0_count_enable == $past(sfr_wdata[4])) else $error("run write");
  chk_t0_set: assert property (timer0_overflow |=> timer0_overflow_flag)
    else $error("t0 flag set");
  chk_t1_set: assert property (!timer0_split_mode && timer1_overflow |=>
    timer1_overflow_flag) else $error("t1 flag set");
  chk_split_set: assert property (timer0_split_mode && timer0_high_overflow |=>
    timer1_overflow_flag) else $error("split flag set");
  chk_t0_ack: assert property (ack_timer0 && !timer0_overflow |=>
    !timer0_overflow_flag) else $error("t0 ack clear");
  chk_t1_ack: assert property (ack_timer1 && !timer1_overflow && !timer0_high_overflow
    |=> !timer1_overflow_flag) else $error("t1 ack clear");
endmodule // ctrl_reg_checker

bind timer_extirq_control_reg ctrl_reg_checker chk_u (.*);

// ---- bench/core_vector_model.sv ----
// processor core vectoring model: acknowledges pending sources
// assumes: pending order timer0, timer1, ext0, ext1 from the block's flags
`timescale 1ns/1ns
module core_vector_model (
  input  wire logic       clock,
  input  wire logic       reset,
  input  wire logic       vector_en,
  input  wire logic [3:0] lag,
  input  wire logic [3:0] pending,
  output logic      [3:0] ack
);
  logic [3:0] wait_r;
  // one source per entry, lowest first, so acks never overlap
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      wait_r <= 4'h0;
      ack    <= 4'h0;
    end else if (ack != 4'h0 || !vector_en || pending == 4'h0) begin
      wait_r <= 4'h0;
      ack    <= 4'h0;
    end else if (wait_r == lag) begin
      wait_r <= 4'h0;
      ack    <= pending & (~pending + 4'h1);
    end else begin
      wait_r <= wait_r + 4'h1;
    end
  end
endmodule // core_vector_model

// ---- bench/tb_top.sv ----
// self-checking bench for the control register block
// assumes: vectoring model on the ack inputs, checker bound into the block
`timescale 1ns/1ns
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin n_fail++; \
  $display("[ERR] %s exp %h got %h", n, e, s); end end
module tb_top;
  logic       clock, reset, sfr_write, sfr_bit_write, sfr_bit_value, sfr_read, sfr_hit;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, img, d, e_v;
  logic [2:0] sfr_bit_index;
  logic       timer0_overflow, timer0_high_overflow, timer1_overflow, timer0_split_mode;
  logic       timer0_gate_enable, timer1_gate_enable, ext_request_0, ext_request_1_n;
  logic       ext_request0_polarity, ext_request1_polarity, vector_en, rd_seen;
  logic       ack_timer0, ack_timer1, ack_ext0, ack_ext1, timer0_count_enable;
  logic       timer0_high_count_enable, timer1_count_enable, timer0_overflow_flag;
  logic       timer1_overflow_flag, ext_irq0_flag, ext_irq1_flag;
  logic [3:0] lag, acks;
  logic [7:0] exp_q[$];
  int         n_fail, compares, cyc;
  timer_extirq_control_reg dut_u (.*);
  core_vector_model core_u (.clock(clock), .reset(reset), .vector_en(vector_en), .lag(lag),
    .pending({ext_irq1_flag, ext_irq0_flag, timer1_overflow_flag, timer0_overflow_flag}),
    .ack(acks));
  assign {ack_ext1, ack_ext0, ack_timer1, ack_timer0} = acks;
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  task automatic test_done();
    if (n_fail == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // read data is compared one edge after the taken read
  always @(posedge clock) begin
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      test_done();
    end
    if (rd_seen) begin
      e_v = exp_q.pop_front();
      `CHK("rdata", e_v, sfr_rdata)
    end
    rd_seen <= sfr_read && sfr_hit;
  end
  task automatic bus(input logic [2:0] op, input logic [7:0] a, v, input logic [2:0] ev);
    {sfr_write, sfr_bit_write, sfr_read} <= op;
    sfr_addr <= a;
    sfr_wdata <= v;
    {sfr_bit_value, sfr_bit_index} <= v[3:0];
    {timer0_high_overflow, timer1_overflow, timer0_overflow} <= ev;
    @(posedge clock);
    {sfr_write, sfr_bit_write, sfr_read} <= 3'b000;
    {timer0_high_overflow, timer1_overflow, timer0_overflow} <= 3'b000;
    @(posedge clock);
  endtask
  task automatic bw(input logic [2:0] i, input logic v, input logic [2:0] ev);
    bus(3'b010, 8'h88, {4'h0, v, i}, ev);
  endtask
  task automatic rd(input logic [7:0] e);
    exp_q.push_back(e);
    bus(3'b001, 8'h88, 8'h00, 3'b000);
  endtask
  initial begin
    {reset, ext_request0_polarity, ext_request1_polarity} = 3'b111;
    {sfr_write, sfr_bit_write, sfr_read, sfr_bit_index, sfr_bit_value} = '0;
    {sfr_addr, sfr_wdata, img, lag, vector_en} = '0;
    {timer0_overflow, timer0_high_overflow, timer1_overflow, timer0_split_mode} = '0;
    {timer0_gate_enable, timer1_gate_enable, ext_request_0, ext_request_1_n} = '0;
    void'($urandom(32'hC48A0627));
    repeat (6) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    rd(8'h00);
    repeat (4) begin
      d = 8'($urandom()) & 8'h55;
      bus(3'b100, 8'h88, d, 3'b000);
      `CHK("t0 en", d[4], timer0_count_enable)
      `CHK("t1 en", d[6], timer1_count_enable)
      bus(3'b100, 8'h89, 8'hFF, 3'b000);
      rd(d);
    end
    bus(3'b100, 8'h88, 8'h00, 3'b000);
    for (int i = 0; i < 8; i += 2) begin
      bw(i[2:0], 1'b1, 3'b000);
      img[i] = 1'b1;
      rd(img);
    end
    {timer0_gate_enable, timer1_gate_enable} <= 2'b11;
    repeat (4) @(posedge clock);
    `CHK("gated", 1'b0, timer0_count_enable)
    `CHK("t1 gated", 1'b0, timer1_count_enable)
    {ext_request_0, ext_request1_polarity} <= 2'b10;
    repeat (4) @(posedge clock);
    `CHK("gate open", 1'b1, timer0_count_enable)
    `CHK("t1 gate open", 1'b1, timer1_count_enable)
    `CHK("x0 edge", 1'b1, ext_irq0_flag)
    `CHK("x1 edge", 1'b1, ext_irq1_flag)
    {timer0_gate_enable, timer1_gate_enable, ext_request_0, ext_request1_polarity} <= 4'b0001;
    bus(3'b000, 8'h88, 8'h00, 3'b001);
    bw(3'd5, 1'b0, 3'b000);
    `CHK("t0 sw clear", 1'b0, timer0_overflow_flag)
    bw(3'd5, 1'b0, 3'b001);
    `CHK("t0 set wins", 1'b1, timer0_overflow_flag)
    bw(3'd7, 1'b0, 3'b010);
    `CHK("t1 set wins", 1'b1, timer1_overflow_flag)
    rd(8'hFF);
    vector_en <= 1'b1;
    lag <= 4'($urandom());
    repeat (80) @(posedge clock);
    rd(8'h55);
    vector_en <= 1'b0;
    timer0_split_mode <= 1'b1;
    bw(3'd6, 1'b1, 3'b010);
    `CHK("split t1 ignored", 1'b0, timer1_overflow_flag)
    `CHK("split high en", 1'b1, timer0_high_count_enable)
    bw(3'd6, 1'b0, 3'b100);
    `CHK("split high ovf", 1'b1, timer1_overflow_flag)
    `CHK("split high off", 1'b0, timer0_high_count_enable)
    timer0_split_mode <= 1'b0;
    bus(3'b100, 8'h88, 8'h00, 3'b000);
    bw(3'd1, 1'b1, 3'b000);
    vector_en <= 1'b1;
    repeat (40) @(posedge clock);
    `CHK("x0 level ack kept", 1'b1, ext_irq0_flag)
    vector_en <= 1'b0;
    bw(3'd1, 1'b0, 3'b000);
    `CHK("x0 level sw clear", 1'b0, ext_irq0_flag)
    {ext_request_0, vector_en} <= 2'b11;
    repeat (40) @(posedge clock);
    `CHK("x0 level held", 1'b1, ext_irq0_flag)
    reset <= 1'b1;
    repeat (2) @(posedge clock);
    {reset, ext_request_0, vector_en} <= 3'b000;
    repeat (4) @(posedge clock);
    rd(8'h00);
    repeat (2) @(posedge clock);
    `CHK("reads left", 0, exp_q.size())
    test_done();
  end
endmodule // tb_top
